//--- rtl/lait_pkg.sv
package lait_pkg;

    // ==========================================
    // Register map (byte offsets, 32-bit data)
    localparam logic [7:0] LAIT_OFF_MIRROR = 8'h00;
    localparam logic [7:0] LAIT_OFF_L2 = 8'h10;
    localparam logic [7:0] LAIT_OFF_STAT = 8'h14;
    localparam logic [7:0] LAIT_OFF_EN = 8'h18;
    localparam logic [7:0] LAIT_OFF_IRQ = 8'h1a;

    // ==========================================
    // Reset values and implemented-bit masks
    localparam logic [31:0] LAIT_STAT_RST = 32'h0000_0000;
    localparam logic [15:0] LAIT_EN_RST = 16'h0000;
    localparam logic [15:0] LAIT_EN_MASK = 16'h0fff;
    localparam logic [15:0] LAIT_IRQ_RST = 16'h0000;
    localparam logic [15:0] LAIT_IRQ_MASK = 16'hdeb8;

    // ==========================================
    // Enable register fields
    localparam int LAIT_EN_FW = 11;
    localparam int LAIT_EN_FRD_HI = 10;
    localparam int LAIT_EN_FRD_LO = 9;
    localparam int LAIT_EN_DMA_HI = 8;
    localparam int LAIT_EN_DMA_LO = 7;
    localparam int LAIT_EN_MPU_HI = 6;
    localparam int LAIT_EN_MPU_LO = 5;
    localparam int LAIT_EN_FR = 4;
    localparam int LAIT_EN_SYNTH = 3;
    localparam int LAIT_EN_SB = 2;
    localparam int LAIT_EN_SEL_HI = 1;

    // ==========================================
    // Status register fields
    localparam int LAIT_ST_EVEN_LSB = 24;
    localparam int LAIT_ST_ODD_LSB = 16;
    localparam int LAIT_ST_A1 = 15;
    localparam int LAIT_ST_DIR = 14;
    localparam int LAIT_ST_CAUSE_LSB = 10;
    // Cause bank index (status bit minus 10)
    localparam int LAIT_CZ_SBFM = 0;
    localparam int LAIT_CZ_MPU = 1;
    localparam int LAIT_CZ_DMA = 2;
    localparam int LAIT_CZ_SBFM_FW = 3;

    // ==========================================
    // Trapped I/O ports
    localparam logic [15:0] LAIT_P_SYNTH_LO = 16'h0388;
    localparam logic [15:0] LAIT_P_SYNTH_HI = 16'h038b;
    localparam logic [15:0] LAIT_P_SB_BASE0 = 16'h0220;
    localparam logic [15:0] LAIT_P_SB_BASE1 = 16'h0240;
    localparam logic [15:0] LAIT_P_MIDI_HI = 16'h0330;
    localparam logic [15:0] LAIT_P_MIDI_LO = 16'h0300;
    localparam logic [15:0] LAIT_P_DMA_LO_A = 16'h0000;
    localparam logic [15:0] LAIT_P_DMA_LO_B = 16'h000f;
    localparam logic [15:0] LAIT_P_DMA_HI_A = 16'h00c0;
    localparam logic [15:0] LAIT_P_DMA_HI_B = 16'h00df;
    localparam logic [1:0] LAIT_SEL_220 = 2'h0;
    localparam logic [1:0] LAIT_SEL_240 = 2'h1;

    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [7:0] data;
    } lait_io_t;

    typedef struct packed {
        logic dma;
        logic midi_port_unit;
        logic sbfm;
        logic fw_even;
        logic fw_odd;
        logic fr;
    } lait_hit_t;

    function automatic logic lait_in_range(input logic [15:0] a, input logic [15:0] lo,
                                           input logic [15:0] hi);
        lait_in_range = (a >= lo) && (a <= hi);
    endfunction

endpackage

//--- rtl/lait_sticky.sv
`timescale 1ns/1ps
module lait_sticky #(
    parameter int W = 4
) (
    // Clock and control
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // Flag events
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    // Flags
    output logic [W-1:0] q_out
);
    import lait_pkg::*;

    logic [W-1:0] flag_reg;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            flag_reg <= '0;
        end else if (ce_in) begin
            flag_reg <= (flag_reg & ~clr_in) | set_in;
        end
    end

    assign q_out = flag_reg;

endmodule

//--- rtl/lait_port_decode.sv
`timescale 1ns/1ps
module lait_port_decode (
    // Access and setup
    input wire lait_pkg::lait_io_t io_in,
    input wire logic [15:0] en_in,
    // Classification
    output lait_pkg::lait_hit_t hit_out
);
    import lait_pkg::*;

    logic [15:0] sb_base;
    logic sb_sel_ok;
    logic sb_win;
    logic syn_win;
    logic [3:0] lo4;
    logic sb_map;
    logic syn_map;
    logic fw_port;
    logic fr_port;

    // Ranges 10 and 11 of the select field map nothing
    assign sb_sel_ok = !en_in[LAIT_EN_SEL_HI];
    assign sb_base = en_in[0] ? LAIT_P_SB_BASE1 : LAIT_P_SB_BASE0;
    assign sb_win = sb_sel_ok && (io_in.addr[15:4] == sb_base[15:4]);
    assign syn_win = lait_in_range(io_in.addr, LAIT_P_SYNTH_LO, LAIT_P_SYNTH_HI);
    assign lo4 = io_in.addr[3:0];
    assign sb_map = en_in[LAIT_EN_SB] && sb_win;
    assign syn_map = en_in[LAIT_EN_SYNTH] && syn_win;

    assign fw_port = (syn_map && (lo4[1:0] != 2'h1))
                  || (sb_map && (lo4 == 4'h0 || lo4 == 4'h2 || lo4 == 4'h8));
    // fast read ports, only with mapping on
    assign fr_port = syn_map
                  || (sb_map && (lo4[3:2] == 2'h0 || lo4[3:1] == 3'h4));

    always_comb begin
        hit_out = '0;
        hit_out.dma = (en_in[LAIT_EN_DMA_HI]
                       && lait_in_range(io_in.addr, LAIT_P_DMA_HI_A, LAIT_P_DMA_HI_B))
                   || (en_in[LAIT_EN_DMA_LO]
                       && lait_in_range(io_in.addr, LAIT_P_DMA_LO_A, LAIT_P_DMA_LO_B));
        hit_out.midi_port_unit = (en_in[LAIT_EN_MPU_HI] && io_in.addr[15:1] == LAIT_P_MIDI_HI[15:1])
                   || (en_in[LAIT_EN_MPU_LO] && io_in.addr[15:1] == LAIT_P_MIDI_LO[15:1]);
        hit_out.sbfm = sb_map || syn_map;
        hit_out.fw_even = en_in[LAIT_EN_FW] && io_in.write && fw_port && !io_in.addr[0];
        hit_out.fw_odd = en_in[LAIT_EN_FW] && io_in.write && fw_port && io_in.addr[0];
        hit_out.fr = en_in[LAIT_EN_FR] && !io_in.write && fr_port;
    end

endmodule

//--- rtl/lait_io_trap.sv
`timescale 1ns/1ps
// Operation
// - even fast write data into 31:24
// - odd fast or normal write into 23:16
// - A1 of last fast write in 15
// - direction of last trap in 14
// - sound/synth cause to 13 or 10
// - DMA cause 12, midi cause 11
// - status read with lane 1 clears 13:10 only
// - trapped address bits 9:0 captured
// - even fast write no SMI, odd sets 13
// - fast write ports when enable 11
// - bits 10:9 feed fast read data
// - enable 8 traps ports C0h-DFh
// - enable 7 traps ports 00h-0Fh
// - enable 6 traps 330h-331h as midi
// - enable 5 traps 300h-301h as midi
// - enable 4 answers status reads directly
// - fast read needs sound/synth mapping on
// - enable 3 traps ports 388h-38Bh
// - enable 2 traps selected sound range
// - any cause sets second-level bit 0
// - IRQ select bit: 0 external, 1 internal
// - second level clears on lane 0 read, mirror not
module lait_io_trap (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // Register port
    input wire logic reg_req_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [3:0] reg_be_in,
    input wire logic [31:0] reg_wdata_in,
    output logic reg_ack_out,
    output logic [31:0] reg_rdata_out,
    // Host I/O cycles seen
    input wire logic io_valid_in,
    input wire lait_pkg::lait_io_t io_in,
    output logic io_done_out,
    output logic io_fast_out,
    output logic [7:0] io_rdata_out,
    // Management outputs
    output logic smi_out,
    output logic l2_trap_out,
    output logic [15:0] irq_internal_out
);
    import lait_pkg::*;

    // ==========================================
    // Storage
    logic [15:0] en_reg;
    logic [15:0] irq_sel_reg;
    logic [7:0] even_data_reg;
    logic [7:0] odd_data_reg;
    logic a1_reg;
    logic dir_reg;
    logic [9:0] addr_reg;
    logic reg_ack_reg;
    logic [31:0] reg_rdata_reg;
    logic io_done_reg;
    logic io_fast_reg;
    logic [7:0] io_rdata_reg;

    // ==========================================
    // Working signals
    lait_hit_t hit;
    logic io_take;
    logic reg_take;
    logic reg_rd;
    logic reg_wr;
    logic trap_any;
    logic sbfm_trap;
    logic fast_any;
    logic [3:0] cause_set;
    logic [3:0] cause_clr;
    logic [3:0] cause_q;
    logic l2_set;
    logic l2_clr;
    logic l2_q;
    logic [31:0] stat_view;
    logic [31:0] l2_view;
    logic [31:0] rd_mux;
    logic [15:0] en_next;
    logic [15:0] irq_sel_next;
    logic sel_mirror;
    logic sel_l2;
    logic sel_stat;
    logic sel_en;

    // ==========================================
    // Port classification
    lait_port_decode u_decode (
        .io_in(io_in),
        .en_in(en_reg),
        .hit_out(hit)
    );

    assign io_take = ce_in && io_valid_in;
    assign reg_take = ce_in && reg_req_in;
    assign reg_rd = reg_take && !reg_wr_in;
    assign reg_wr = reg_take && reg_wr_in;

    // ==========================================
    // Register word decode
    // Byte offsets inside a word are not decoded; they read zero
    function automatic logic word_sel(input logic [7:0] a, input logic [7:0] off);
        word_sel = (a == off);
    endfunction

    assign sel_mirror = word_sel(reg_addr_in, LAIT_OFF_MIRROR);
    assign sel_l2 = word_sel(reg_addr_in, LAIT_OFF_L2);
    assign sel_stat = word_sel(reg_addr_in, LAIT_OFF_STAT);
    assign sel_en = word_sel(reg_addr_in, LAIT_OFF_EN);

    // ==========================================
    // Trap qualification
    // Fast-path handled accesses never raise the plain trap
    assign fast_any = hit.fw_even || hit.fw_odd || hit.fr;

    // sound or synth window raises SMI
    assign sbfm_trap = hit.sbfm && !fast_any;

    assign trap_any = io_take && (hit.dma || hit.midi_port_unit || sbfm_trap || hit.fw_odd);

    always_comb begin
        cause_set = 4'h0;
        if (io_take) begin
            // report site follows fast write enable
            if (sbfm_trap) begin
                if (en_reg[LAIT_EN_FW]) begin
                    cause_set[LAIT_CZ_SBFM_FW] = 1'b1;
                end else begin
                    cause_set[LAIT_CZ_SBFM] = 1'b1;
                end
            end
            // odd fast write always reports in 13
            if (hit.fw_odd) begin
                cause_set[LAIT_CZ_SBFM_FW] = 1'b1;
            end
            if (hit.dma) begin
                cause_set[LAIT_CZ_DMA] = 1'b1;
            end
            if (hit.midi_port_unit) begin
                cause_set[LAIT_CZ_MPU] = 1'b1;
            end
        end
    end

    // ==========================================
    // Read-to-clear flags
    // status read clears cause bits, lane 1
    assign cause_clr = (reg_rd && sel_stat && reg_be_in[1]) ? 4'hf : 4'h0;

    lait_sticky #(
        .W(4)
    ) u_cause (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .set_in(cause_set),
        .clr_in(cause_clr),
        .q_out(cause_q)
    );

    // each cause also marks the second level
    assign l2_set = |cause_set;
    // clearing copy at low half only
    assign l2_clr = reg_rd && sel_l2 && reg_be_in[0];

    lait_sticky #(
        .W(1)
    ) u_l2 (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .set_in(l2_set),
        .clr_in(l2_clr),
        .q_out(l2_q)
    );

    // ==========================================
    // Captured access details
    // even fast write data only
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            even_data_reg <= LAIT_STAT_RST[31:24];
        end else if (io_take && hit.fw_even) begin
            even_data_reg <= io_in.data;
        end
    end

    // odd fast write or any ordinary write
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            odd_data_reg <= LAIT_STAT_RST[23:16];
        end else if (io_take && io_in.write && !hit.fw_even) begin
            odd_data_reg <= io_in.data;
        end
    end

    // A1 of the last fast write
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            a1_reg <= LAIT_STAT_RST[LAIT_ST_A1];
        end else if (io_take && (hit.fw_even || hit.fw_odd)) begin
            a1_reg <= io_in.addr[1];
        end
    end

    // direction of the last trapped access
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            dir_reg <= LAIT_STAT_RST[LAIT_ST_DIR];
        end else if (trap_any) begin
            dir_reg <= io_in.write;
        end
    end

    // address of trapped or fast-written access
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            addr_reg <= LAIT_STAT_RST[9:0];
        end else if (trap_any || (io_take && hit.fw_even)) begin
            addr_reg <= io_in.addr[9:0];
        end
    end

    // ==========================================
    // I/O cycle answer
    // Answer one cycle later; data held until the next fast read
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            io_done_reg <= 1'b0;
            io_fast_reg <= 1'b0;
        end else if (ce_in) begin
            io_done_reg <= io_valid_in;
            io_fast_reg <= io_valid_in && (hit.fw_even || hit.fr);
        end
    end

    // software bits lead the fast read byte
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            io_rdata_reg <= 8'h00;
        end else if (io_take && hit.fr) begin
            io_rdata_reg <= {en_reg[LAIT_EN_FRD_HI:LAIT_EN_FRD_LO], 6'h00};
        end
    end

    // ==========================================
    // Register write path
    always_comb begin
        en_next = en_reg;
        if (reg_wr && sel_en) begin
            if (reg_be_in[0]) begin
                en_next[7:0] = reg_wdata_in[7:0];
            end
            if (reg_be_in[1]) begin
                en_next[15:8] = reg_wdata_in[15:8];
            end
        end
        en_next = en_next & LAIT_EN_MASK;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            en_reg <= LAIT_EN_RST;
        end else if (ce_in) begin
            en_reg <= en_next;
        end
    end

    // both upper lanes 3:2 only; a single-lane write is dropped
    // Select word sits in the upper half of the enable word
    always_comb begin
        irq_sel_next = irq_sel_reg;
        if (reg_wr && sel_en && reg_be_in[3:2] == 2'h3) begin
            irq_sel_next = reg_wdata_in[31:16] & LAIT_IRQ_MASK;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            irq_sel_reg <= LAIT_IRQ_RST;
        end else if (ce_in) begin
            irq_sel_reg <= irq_sel_next;
        end
    end

    // ==========================================
    // Register read path
    assign stat_view = {even_data_reg, odd_data_reg, a1_reg, dir_reg, cause_q, addr_reg};
    assign l2_view = {15'h0000, l2_q, 15'h0000, l2_q};

    always_comb begin
        // Mirror shows the flag but has no clear path
        if (sel_mirror) begin
            rd_mux = {16'h0000, l2_view[15:0]};
        end else if (sel_l2) begin
            rd_mux = l2_view;
        end else if (sel_stat) begin
            rd_mux = stat_view;
        end else if (sel_en) begin
            rd_mux = {irq_sel_reg, en_reg};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    // Value before any clear is what software sees
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            reg_ack_reg <= 1'b0;
            reg_rdata_reg <= 32'h0000_0000;
        end else if (ce_in) begin
            reg_ack_reg <= reg_req_in;
            if (reg_rd) begin
                reg_rdata_reg <= rd_mux;
            end
        end
    end

    // ==========================================
    // Outputs
    assign reg_ack_out = reg_ack_reg;
    assign reg_rdata_out = reg_rdata_reg;
    assign io_done_out = io_done_reg;
    assign io_fast_out = io_fast_reg;
    assign io_rdata_out = io_rdata_reg;

    // request stays up while any cause bit stands
    assign smi_out = (|cause_q) || l2_q;
    // second-level trap flag toward the top level
    assign l2_trap_out = l2_q;
    // 1 selects internal use of that line
    assign irq_internal_out = irq_sel_reg;

endmodule

//--- sim/lait_io_trap_monitor.sv
`timescale 1ns/1ps
module lait_io_trap_monitor
    import lait_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // Register port
    input wire logic reg_req_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [3:0] reg_be_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_ack_out,
    input wire logic [31:0] reg_rdata_out,
    // Host I/O cycles
    input wire logic io_valid_in,
    input wire lait_io_t io_in,
    input wire logic io_done_out,
    input wire logic io_fast_out,
    input wire logic [7:0] io_rdata_out,
    // Management outputs
    input wire logic smi_out,
    input wire logic l2_trap_out,
    input wire logic [15:0] irq_internal_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    // ==========================================
    // Assertions
    a_io_done_next: assert property (ce_in && io_valid_in |=> io_done_out)
        else $error("io cycle not answered");
    a_reg_ack_next: assert property (ce_in && reg_req_in |=> reg_ack_out)
        else $error("register access not acknowledged");
    a_fast_no_smi: assert property (io_done_out && io_fast_out |-> !$rose(smi_out))
        else $error("fast path raised smi");
    a_smi_rise_cause: assert property ($rose(smi_out) |-> io_done_out && !io_fast_out)
        else $error("smi rose without a trapped cycle");
    // Reset itself may drop smi, so the edge after reset is excluded
    a_smi_fall_read: assert property ($fell(smi_out) && $past(nrst_in) |-> $past(ce_in && reg_req_in && !reg_wr_in))
        else $error("smi dropped without a read");
    a_l2_in_smi: assert property (l2_trap_out |-> smi_out)
        else $error("second level flag without smi");
    a_fread_low_zero: assert property (io_rdata_out[5:0] == 6'h0)
        else $error("fast read low bits not zero");
    a_cause_sets_l2: assert property ($rose(smi_out) |-> l2_trap_out)
        else $error("smi rose without second level flag");
    a_fread_hold: assert property (!$stable(io_rdata_out) && $past(nrst_in) |-> io_done_out && io_fast_out && $past(!io_in.write))
        else $error("fast read byte changed without a fast read");
    a_irq_reserved: assert property ((irq_internal_out & ~LAIT_IRQ_MASK) == 16'h0)
        else $error("reserved irq select bit set");
    a_irq_word_only: assert property (!$stable(irq_internal_out) && $past(nrst_in) |->
        $past(ce_in && reg_req_in && reg_wr_in && reg_addr_in == LAIT_OFF_EN && reg_be_in[3:2] == 2'b11))
        else $error("irq select changed without word write");
    a_rdata_hold: assert property (!$stable(reg_rdata_out) && $past(nrst_in) |-> reg_ack_out && $past(!reg_wr_in))
        else $error("read data changed without a read");

    c_trap_smi: cover property (ce_in && io_valid_in && io_in.write ##1 smi_out);
    c_fast_path: cover property (io_done_out && io_fast_out);
    c_smi_cleared: cover property ($fell(smi_out));
endmodule

bind lait_io_trap lait_io_trap_monitor i_lait_io_trap_monitor (.*);

//--- sim/lait_host.sv
`timescale 1ns/1ps
module lait_host
    import lait_pkg::*;
(
    // Clock and answers
    input wire logic clk_in,
    input wire logic reg_ack_in,
    input wire logic [31:0] reg_rdata_in,
    input wire logic io_done_in,
    // Requests
    output logic reg_req_out,
    output logic reg_wr_out,
    output logic [7:0] reg_addr_out,
    output logic [3:0] reg_be_out,
    output logic [31:0] reg_wdata_out,
    output logic io_valid_out,
    output lait_io_t io_out
);
    initial begin
        reg_req_out = 1'b0;
        reg_wr_out = 1'b0;
        reg_addr_out = 8'h0;
        reg_be_out = 4'h0;
        reg_wdata_out = 32'h0;
        io_valid_out = 1'b0;
        io_out = '0;
    end

    // ==========================================
    // One pulse per access; answer lands one cycle later
    // Byte enables sent as given; IRQ select lanes may go singly
    task automatic reg_xfer(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                            input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        @(posedge clk_in);
        #1;
        reg_req_out = 1'b1;
        reg_wr_out = wr;
        reg_addr_out = addr;
        reg_be_out = be;
        reg_wdata_out = wd;
        @(posedge clk_in);
        #1;
        reg_req_out = 1'b0;
        reg_wdata_out = ~wd;
        ok = reg_ack_in;
        rd = reg_rdata_in;
    endtask

    // Data bus not held after the cycle, so stale values never match
    task automatic io_xfer(input logic wr, input logic [15:0] addr, input logic [7:0] d, output logic ok);
        @(posedge clk_in);
        #1;
        io_valid_out = 1'b1;
        io_out = '{write: wr, addr: addr, data: d};
        @(posedge clk_in);
        #1;
        io_valid_out = 1'b0;
        io_out.data = ~d;
        ok = io_done_in;
    endtask
endmodule

//--- sim/tb_lait_io_trap.sv
`timescale 1ns/1ps
module tb_lait_io_trap;
    import lait_pkg::*;
    logic clk_in, nrst_in, ce_in, reg_req_in, reg_wr_in, reg_ack_out, io_valid_in, io_done_out, io_fast_out;
    logic smi_out, l2_trap_out, ok, l2, w;
    logic [7:0] reg_addr_in, io_rdata_out, d;
    logic [3:0] reg_be_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, rd, st;
    logic [15:0] irq_internal_out, en, a;
    lait_io_t io_in;
    lait_hit_t h;
    int fails, n_compared, seed, i;
    localparam logic [15:0] PORTS [12] = '{16'h0388, 16'h0220, 16'h0228, 16'h0240, 16'h0248, 16'h0330,
                                          16'h0300, 16'h00c0, 16'h00dd, 16'h000e, 16'h022e, 16'h0387};

    lait_io_trap i_lait_io_trap (.*);
    lait_host i_lait_host (.clk_in(clk_in), .reg_ack_in(reg_ack_out), .reg_rdata_in(reg_rdata_out),
        .io_done_in(io_done_out), .reg_req_out(reg_req_in), .reg_wr_out(reg_wr_in), .reg_addr_out(reg_addr_in),
        .reg_be_out(reg_be_in), .reg_wdata_out(reg_wdata_in), .io_valid_out(io_valid_in), .io_out(io_in));

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d, wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp, input string what);
        i_lait_host.reg_xfer(1'b0, ad, 4'hf, 32'h0, rd, ok);
        check("ack", {31'h0, ok}, 32'h1);
        check(what, rd, exp);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [3:0] be, input logic [31:0] wd);
        i_lait_host.reg_xfer(1'b1, ad, be, wd, rd, ok);
        check("ack", {31'h0, ok}, 32'h1);
    endtask

    // ==========================================
    // Reference classification of one host cycle
    function automatic lait_hit_t classify(input logic [15:0] e, input logic wx, input logic [15:0] ax);
        logic sb, fm, fw;
        lait_hit_t r;
        sb = e[2] && !e[1] && ax[15:4] == (e[0] ? 12'h024 : 12'h022);
        fm = e[3] && ax >= 16'h0388 && ax <= 16'h038b;
        fw = e[11] && wx && ((fm && ax != 16'h0389) || (sb && ax[3:0] inside {4'h0, 4'h2, 4'h8}));
        r.fr = e[4] && !wx && (fm || (sb && ax[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9}));
        r.fw_even = fw && !ax[0];
        r.fw_odd = fw && ax[0];
        r.sbfm = sb || fm;
        r.dma = (e[8] && ax >= 16'h00c0 && ax <= 16'h00df) || (e[7] && ax <= 16'h000f);
        r.midi_port_unit = (e[6] && ax[15:1] == 15'h0198) || (e[5] && ax[15:1] == 15'h0180);
        return r;
    endfunction

    task automatic do_io(input logic wx, input logic [15:0] ax, input logic [7:0] dx);
        logic trap;
        h = classify(en, wx, ax);
        i_lait_host.io_xfer(wx, ax, dx, ok);
        trap = !h.fw_even && !h.fr && (h.sbfm || h.dma || h.midi_port_unit);
        if (wx && !h.fw_even) st[23:16] = dx;
        if (h.fw_even) st[31:24] = dx;
        if (h.fw_even || h.fw_odd) st[15] = ax[1];
        if (trap) begin
            st[14] = wx;
            st[12] = st[12] | h.dma;
            st[11] = st[11] | h.midi_port_unit;
            if (h.sbfm) st[en[11] ? 13 : 10] = 1'b1;
        end
        if (trap || h.fw_even) st[9:0] = ax[9:0];
        l2 = l2 | trap;
        check("done", {31'h0, ok}, 32'h1);
        check("fast", {31'h0, io_fast_out}, {31'h0, h.fw_even || h.fr});
        if (h.fr) check("fast read", {24'h0, io_rdata_out}, {24'h0, en[10:9], 6'h0});
        check("smi", {31'h0, smi_out}, {31'h0, l2 || st[13:10] != 4'h0});
    endtask

    task automatic drain();
        rd_chk(LAIT_OFF_STAT, st, "status");
        st[13:10] = 4'h0;
        rd_chk(LAIT_OFF_MIRROR, {31'h0, l2}, "mirror");
        rd_chk(LAIT_OFF_L2, {15'h0, l2, 15'h0, l2}, "second level");
        l2 = 1'b0;
        check("smi cleared", {31'h0, smi_out}, 32'h0);
    endtask

    initial begin
        seed = 32'ha2a7;
        fails = 0;
        n_compared = 0;
        ce_in = 1'b1;
        nrst_in = 1'b0;
        st = LAIT_STAT_RST;
        l2 = 1'b0;
        en = LAIT_EN_RST;
        repeat (3) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        rd_chk(LAIT_OFF_STAT, LAIT_STAT_RST, "status reset");
        rd_chk(LAIT_OFF_EN, 32'h0, "enable reset");
        rd_chk(8'h20, 32'h0, "unmapped");
        $display("test reset done");
        wr(LAIT_OFF_EN, 4'hf, 32'hffff_f000);
        check("irq", {16'h0, irq_internal_out}, {16'h0, LAIT_IRQ_MASK});
        wr(LAIT_OFF_EN, 4'h4, 32'h0);
        rd_chk(LAIT_OFF_EN, {LAIT_IRQ_MASK, 16'h0}, "irq half word");
        wr(LAIT_OFF_EN, 4'hc, 32'h4000_0000);
        check("irq bit 14", {16'h0, irq_internal_out}, 32'h4000);
        $display("test irq select done");
        en = 16'h0808;
        wr(LAIT_OFF_EN, 4'h3, {16'h0, en});
        do_io(1'b1, 16'h038b, 8'h5a);
        do_io(1'b1, 16'h0388, 8'ha5);
        // Status read on lane 0 only leaves the cause bits standing
        i_lait_host.reg_xfer(1'b0, LAIT_OFF_STAT, 4'h1, 32'h0, rd, ok);
        check("walk", rd, 32'ha55a_6388);
        drain();
        $display("test fast write done");
        ce_in = 1'b0;
        i_lait_host.io_xfer(1'b1, 16'h038b, 8'h11, ok);
        check("frozen done", {31'h0, ok}, 32'h0);
        check("frozen smi", {31'h0, smi_out}, 32'h0);
        ce_in = 1'b1;
        $display("test clock enable done");
        for (i = 0; i < 400; i++) begin
            if (i % 8 == 0) begin
                en = 16'($random(seed)) & LAIT_EN_MASK;
                wr(LAIT_OFF_EN, 4'h3, {16'h0, en});
            end
            w = 1'($random(seed));
            a = PORTS[$unsigned($random(seed)) % 12] + 16'($unsigned($random(seed)) % 4);
            d = 8'($random(seed));
            do_io(w, a, d);
            if (i % 3 == 2) drain();
        end
        drain();
        $display("test random traffic done");
        end_of_test();
    end

    initial begin
        #500000;
        fails++;
        end_of_test();
    end
endmodule
